// ### inc/bioc_pkg.sv
// package: register map, mode codes and reset values of the port block
package bioc_pkg;
    localparam int          BIOC_WIDTH         = 8;
    localparam logic [7:0]  BIOC_OFF_DATA_A    = 8'hC0;
    localparam logic [7:0]  BIOC_OFF_DATA_B    = 8'hC1;
    localparam logic [7:0]  BIOC_OFF_DIR_A     = 8'hC4;
    localparam logic [7:0]  BIOC_OFF_DIR_B     = 8'hC5;
    localparam logic [7:0]  BIOC_OFF_OPT_A     = 8'hCC;
    localparam logic [7:0]  BIOC_OFF_OPT_B     = 8'hCD;
    localparam logic [7:0]  BIOC_RESET_VALUE   = 8'h00;
    localparam logic [1:0]  BIOC_TRIG_FALL     = 2'h0;
    localparam logic [1:0]  BIOC_TRIG_RISE     = 2'h1;
    localparam logic [1:0]  BIOC_TRIG_LOW      = 2'h2;
    localparam logic [2:0]  BIOC_ADC_SEL_RESET = 3'h0;
    // pads sit high on their pull-ups once reset has cleared every mode
    localparam logic [7:0]  BIOC_PIN_IDLE      = 8'hFF;

    // per-line decoded mode, one-hot
    typedef enum logic [5:0] {
        BIOC_IN_PULLUP  = 6'b000001,
        BIOC_IN_HIZ     = 6'b000010,
        BIOC_IN_IRQ     = 6'b000100,
        BIOC_IN_ANALOG  = 6'b001000,
        BIOC_OUT_OD     = 6'b010000,
        BIOC_OUT_PP     = 6'b100000
    } bioc_mode_e;
endpackage

// ### inc/bioc_bank_if.sv
// interface: one bank's configuration and pin signals between top and bank logic
`timescale 1ns/100ps
interface bioc_bank_if #(parameter int W = 8);
    logic [W-1:0] data_q;
    logic [W-1:0] dir_q;
    logic [W-1:0] opt_q;
    logic [W-1:0] pin_sync;
    logic [1:0]   trig_mode;
    logic [W-1:0] pin_out;
    logic [W-1:0] pin_oe_n;
    logic [W-1:0] pull_en;
    logic [W-1:0] analog_sel;
    logic [W-1:0] read_val;
    logic         irq;
    modport top  (output data_q, dir_q, opt_q, pin_sync, trig_mode,
                  input pin_out, pin_oe_n, pull_en, analog_sel, read_val, irq);
    modport bank (input data_q, dir_q, opt_q, pin_sync, trig_mode,
                  output pin_out, pin_oe_n, pull_en, analog_sel, read_val, irq);
endinterface

// ### rtl/bioc_bank.sv
// bank logic: per-line mode decode, pin drive, read mux and interrupt trigger
`timescale 1ns/100ps
module bioc_bank
    import bioc_pkg::*;
#(
    parameter int W = BIOC_WIDTH
) (
    input  wire logic sys_clk,
    input  wire logic rstn,
    bioc_bank_if.bank bus
);
    typedef struct packed {
        logic [W-1:0] pin_prev;
        logic         irq;
    } bioc_bank_s;

    // a zero here would fake a rising edge just after reset
    localparam bioc_bank_s BIOC_BANK_RST = '{pin_prev: BIOC_PIN_IDLE[W-1:0], irq: 1'b0};

    bioc_bank_s st_reg;
    bioc_bank_s st_next;
    logic [W-1:0] irq_lines;

    function automatic bioc_mode_e bioc_decode(input logic d, input logic o, input logic v);
        bioc_mode_e m;
        m = BIOC_IN_PULLUP;
        unique case ({d, o, v})
            3'b000: m = BIOC_IN_PULLUP;   // R1
            3'b001: m = BIOC_IN_HIZ;      // R1
            3'b010: m = BIOC_IN_IRQ;      // R1
            3'b011: m = BIOC_IN_ANALOG;   // R1
            3'b100,
            3'b101: m = BIOC_OUT_OD;      // R2
            3'b110,
            3'b111: m = BIOC_OUT_PP;      // R2
        endcase
        return m;
    endfunction

    always_comb begin
        bioc_mode_e m;
        m = BIOC_IN_PULLUP;
        for (int i = 0; i < W; i++) begin
            m = bioc_decode(bus.dir_q[i], bus.opt_q[i], bus.data_q[i]); // R7
            bus.pull_en[i]    = (m == BIOC_IN_PULLUP) || (m == BIOC_IN_IRQ); // R14
            bus.analog_sel[i] = (m == BIOC_IN_ANALOG); // R4
            irq_lines[i]      = (m == BIOC_IN_IRQ);
            bus.pin_out[i]    = bus.data_q[i]; // R13
            // open drain: enable only while driving low; oe is active low
            bus.pin_oe_n[i]   = !((m == BIOC_OUT_PP) ||
                                  ((m == BIOC_OUT_OD) && !bus.data_q[i])); // R2
            bus.read_val[i]   = bus.dir_q[i] ? bus.data_q[i] : bus.pin_sync[i]; // R6
        end
    end

    always_comb begin
        logic any;
        any = 1'b0;
        st_next = st_reg;
        st_next.pin_prev = bus.pin_sync;
        for (int i = 0; i < W; i++) begin
            unique case (bus.trig_mode)
                BIOC_TRIG_FALL: any |= irq_lines[i] & st_reg.pin_prev[i] & !bus.pin_sync[i];
                BIOC_TRIG_RISE: any |= irq_lines[i] & !st_reg.pin_prev[i] & bus.pin_sync[i];
                default:        any |= irq_lines[i] & !bus.pin_sync[i]; // R3
            endcase
        end
        st_next.irq = any; // R3
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st_reg <= BIOC_BANK_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    assign bus.irq = st_reg.irq;
endmodule

// ### rtl/bioc_top.sv
// top: two byte-wide configurable port banks behind data-space registers
`timescale 1ns/100ps
// What this block does
// R1 - input: 00 pull-up, 01 hiz, 10 irq, 11 analog
// R2 - output: option 0 open-drain, 1 push-pull
// R3 - interrupt lines trigger on fall, rise or low
// R4 - analog lines routed to converter multiplexer
// R5 - software selects at most one analog line
// R6 - input lines read back pin level
// R7 - data latch selects input characteristics
// R8 - software avoids bit read-modify-write on inputs
// R9 - software masks unimplemented bits
// R10 - registers at C0/C1, C4/C5, CC/CD
// R11 - software uses only safe mode transitions
// R12 - reset clears all registers, pull-up inputs
// R13 - output lines drive data latch value
// R14 - input without pull-up is high impedance
module bioc_top
    import bioc_pkg::*;
#(
    parameter int W = BIOC_WIDTH
) (
    input  wire logic         sys_clk,
    input  wire logic         rstn,
    input  wire logic [7:0]   reg_addr,
    input  wire logic         reg_wr,
    input  wire logic         reg_rd,
    input  wire logic [7:0]   reg_wdata,
    output logic      [7:0]   reg_rdata,
    output logic              reg_hit,
    input  wire logic [1:0]   trig_mode_a,
    input  wire logic [1:0]   trig_mode_b,
    input  wire logic [W-1:0] bank_a_pin_in,
    output logic      [W-1:0] bank_a_pin_out,
    output logic      [W-1:0] bank_a_pin_oe_n,
    output logic      [W-1:0] bank_a_pull_en,
    input  wire logic [W-1:0] bank_b_pin_in,
    output logic      [W-1:0] bank_b_pin_out,
    output logic      [W-1:0] bank_b_pin_oe_n,
    output logic      [W-1:0] bank_b_pull_en,
    output logic      [2*W-1:0] analog_sel,
    output logic              irq_a,
    output logic              irq_b
);
    // one byte per bank on the register bus, so wider banks cannot be served
    if (W < 1 || W > 8) begin
        $error("bioc_top: W must be 1..8");
    end

    typedef struct packed {
        logic [W-1:0] data_a;
        logic [W-1:0] data_b;
        logic [W-1:0] dir_a;
        logic [W-1:0] dir_b;
        logic [W-1:0] opt_a;
        logic [W-1:0] opt_b;
        logic [W-1:0] meta_a;
        logic [W-1:0] sync_a;
        logic [W-1:0] meta_b;
        logic [W-1:0] sync_b;
        logic [7:0]   rdata;
        logic         hit;
    } bioc_top_s;

    bioc_top_s st_reg;
    bioc_top_s st_next;
    logic [5:0] reg_sel;

    // synchronisers start at the idle pad level, so no false edge follows reset
    localparam bioc_top_s BIOC_TOP_RST = '{
        data_a: '0,
        data_b: '0,
        dir_a:  '0,
        dir_b:  '0,
        opt_a:  '0,
        opt_b:  '0,
        meta_a: BIOC_PIN_IDLE[W-1:0],
        sync_a: BIOC_PIN_IDLE[W-1:0],
        meta_b: BIOC_PIN_IDLE[W-1:0],
        sync_b: BIOC_PIN_IDLE[W-1:0],
        rdata:  BIOC_RESET_VALUE,
        hit:    1'b0
    };

    bioc_bank_if #(.W(W)) if_a ();
    bioc_bank_if #(.W(W)) if_b ();

    assign if_a.data_q    = st_reg.data_a;
    assign if_a.dir_q     = st_reg.dir_a;
    assign if_a.opt_q     = st_reg.opt_a;
    assign if_a.pin_sync  = st_reg.sync_a;
    assign if_a.trig_mode = trig_mode_a;
    assign if_b.data_q    = st_reg.data_b;
    assign if_b.dir_q     = st_reg.dir_b;
    assign if_b.opt_q     = st_reg.opt_b;
    assign if_b.pin_sync  = st_reg.sync_b;
    assign if_b.trig_mode = trig_mode_b;

    bioc_bank #(.W(W)) u_bank_a (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .bus     (if_a.bank)
    );

    bioc_bank #(.W(W)) u_bank_b (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .bus     (if_b.bank)
    );

    function automatic logic [7:0] bioc_widen(input logic [W-1:0] v);
        logic [7:0] r;
        r = BIOC_RESET_VALUE;
        r[W-1:0] = v;
        return r;
    endfunction

    // one-hot register select, shared by the write and the read path
    function automatic logic [5:0] bioc_reg_sel(input logic [7:0] a);
        logic [5:0] s;
        s = 6'h00;
        unique case (a) // R10
            BIOC_OFF_DATA_A: s = 6'h01;
            BIOC_OFF_DATA_B: s = 6'h02;
            BIOC_OFF_DIR_A:  s = 6'h04;
            BIOC_OFF_DIR_B:  s = 6'h08;
            BIOC_OFF_OPT_A:  s = 6'h10;
            BIOC_OFF_OPT_B:  s = 6'h20;
            default:         s = 6'h00;
        endcase
        return s;
    endfunction

    assign reg_sel = bioc_reg_sel(reg_addr); // R10

    always_comb begin
        st_next = st_reg;
        // pins are asynchronous to sys_clk; two stages before any reader
        st_next.meta_a = bank_a_pin_in;
        st_next.sync_a = st_reg.meta_a;
        st_next.meta_b = bank_b_pin_in;
        st_next.sync_b = st_reg.meta_b;
        st_next.rdata  = BIOC_RESET_VALUE;
        st_next.hit    = 1'b0;
        // unmapped writes fall through; bits above W are dropped on purpose
        if (reg_wr) begin
            if (reg_sel[0]) st_next.data_a = reg_wdata[W-1:0]; // R10
            if (reg_sel[1]) st_next.data_b = reg_wdata[W-1:0]; // R10
            if (reg_sel[2]) st_next.dir_a  = reg_wdata[W-1:0]; // R10
            if (reg_sel[3]) st_next.dir_b  = reg_wdata[W-1:0]; // R10
            if (reg_sel[4]) st_next.opt_a  = reg_wdata[W-1:0]; // R10
            if (reg_sel[5]) st_next.opt_b  = reg_wdata[W-1:0]; // R10
        end
        if (reg_rd) begin
            st_next.hit = |reg_sel; // R10
            unique case (reg_sel) // R10
                // input lines show the pin, not the latch
                6'h01:   st_next.rdata = bioc_widen(if_a.read_val); // R6
                6'h02:   st_next.rdata = bioc_widen(if_b.read_val); // R6
                6'h04:   st_next.rdata = bioc_widen(st_reg.dir_a);
                6'h08:   st_next.rdata = bioc_widen(st_reg.dir_b);
                6'h10:   st_next.rdata = bioc_widen(st_reg.opt_a);
                6'h20:   st_next.rdata = bioc_widen(st_reg.opt_b);
                default: st_next.rdata = BIOC_RESET_VALUE;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st_reg <= BIOC_TOP_RST; // R12
        end else begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata       = st_reg.rdata;
    assign reg_hit         = st_reg.hit;
    assign bank_a_pin_out  = if_a.pin_out;
    assign bank_a_pin_oe_n = if_a.pin_oe_n;
    assign bank_a_pull_en  = if_a.pull_en;
    assign bank_b_pin_out  = if_b.pin_out;
    assign bank_b_pin_oe_n = if_b.pin_oe_n;
    assign bank_b_pull_en  = if_b.pull_en;
    // several analog lines at once would short pins; not blocked here
    assign analog_sel      = {if_b.analog_sel, if_a.analog_sel}; // R4
    assign irq_a           = if_a.irq;
    assign irq_b           = if_b.irq;
endmodule

// ### test/bioc_pin_model.sv
// pin model: pad level from block drive, outside driver and pull-up
`timescale 1ns/100ps
module bioc_pin_model #(
    parameter int W = 8
) (
    input  wire logic         sys_clk,
    input  wire logic [W-1:0] pin_out,
    input  wire logic [W-1:0] pin_oe_n,
    input  wire logic [W-1:0] pull_en,
    input  wire logic [W-1:0] ext_en,
    input  wire logic [W-1:0] ext_val,
    output logic      [W-1:0] pin_in
);
    logic tog = 1'b0;
    always @(posedge sys_clk) tog <= ~tog;
    // floating pad wanders, so a stale level never reads as valid
    assign pin_in = (~pin_oe_n & pin_out)
                  | (pin_oe_n & ext_en & ext_val)
                  | (pin_oe_n & ~ext_en & (pull_en | {W{tog}}));
endmodule

// ### test/bioc_top_assertions.sv
// checker: port-level properties of the port block
`timescale 1ns/100ps
module bioc_top_assertions
    import bioc_pkg::*;
#(
    parameter int W = BIOC_WIDTH
) (
    input wire logic           sys_clk,
    input wire logic           rstn,
    input wire logic [7:0]     reg_addr,
    input wire logic           reg_rd,
    input wire logic [7:0]     reg_rdata,
    input wire logic           reg_hit,
    input wire logic [1:0]     trig_mode_b,
    input wire logic [W-1:0]   bank_a_pin_oe_n,
    input wire logic [W-1:0]   bank_a_pull_en,
    input wire logic [W-1:0]   bank_b_pin_oe_n,
    input wire logic [W-1:0]   bank_b_pull_en,
    input wire logic [2*W-1:0] analog_sel,
    input wire logic           irq_b
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    wire mapped = reg_addr inside {BIOC_OFF_DATA_A, BIOC_OFF_DATA_B, BIOC_OFF_DIR_A,
                                   BIOC_OFF_DIR_B, BIOC_OFF_OPT_A, BIOC_OFF_OPT_B};
    wire [2*W-1:0] oe_n = {bank_b_pin_oe_n, bank_a_pin_oe_n};
    wire [2*W-1:0] pull = {bank_b_pull_en, bank_a_pull_en};
    a_drive_no_pull: assert property ((~oe_n & pull) == '0)
        else $error("pull-up on driven line");
    a_analog_float: assert property ((analog_sel & (~oe_n | pull)) == '0)
        else $error("analog line driven or pulled");
    a_hit_mapped: assert property (reg_rd && mapped |=> reg_hit)
        else $error("mapped read without hit");
    a_hit_cause: assert property (reg_hit |-> $past(reg_rd) && $past(mapped))
        else $error("hit without mapped read");
    a_unmapped_quiet: assert property (reg_rd && !mapped |=> !reg_hit && reg_rdata == 8'h00)
        else $error("unmapped read answered");
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data without read");
    a_edge_pulse: assert property (irq_b && !trig_mode_b[1] |=> !irq_b || trig_mode_b[1])
        else $error("edge request longer than one cycle");
    a_irq_source: assert property (irq_b |-> $past(|bank_b_pull_en))
        else $error("request with no interrupt line");
endmodule

// ### test/test_bioc_top.sv
// bench: register map, pin modes, interrupts and reset of the port block
`timescale 1ns/100ps
module test_bioc_top;
    import bioc_pkg::*;
    logic        sys_clk = 1'b0;
    logic        rstn = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_wdata = 8'h00;
    logic [1:0]  trig_mode_b = BIOC_TRIG_FALL;
    logic [7:0]  ext_en_b = 8'h0E;
    logic [7:0]  ext_val_b = 8'h0E;
    logic [1:0]  trig_mode_a = BIOC_TRIG_FALL;
    logic [7:0]  ext_en_a = 8'h01;
    logic [7:0]  ext_val_a = 8'h01;
    // all eight lines exist, so the mask keeps every bit
    localparam logic [7:0] line_mask = 8'hFF;
    logic [7:0]  reg_rdata, a_in, a_out, a_oe_n, a_pull, b_in, b_out, b_oe_n, b_pull;
    logic [15:0] analog_sel;
    logic        reg_hit, irq_a, irq_b;
    int          mismatches = 0;
    int          checks = 0;
    int          n;
    // one analog line only, so no pins are shorted; data goes in whole bytes
    logic [23:0] rows [7] = '{24'hC4FFFF, 24'hCC3C3C, 24'hC05A5A, 24'hC50000,
                              24'hCD0C0C, 24'hC10AFF, 24'hC27700};
    bioc_top #(.W(8)) uut (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_hit(reg_hit), .trig_mode_a(trig_mode_a), .trig_mode_b(trig_mode_b),
        .bank_a_pin_in(a_in), .bank_a_pin_out(a_out), .bank_a_pin_oe_n(a_oe_n),
        .bank_a_pull_en(a_pull), .bank_b_pin_in(b_in), .bank_b_pin_out(b_out),
        .bank_b_pin_oe_n(b_oe_n), .bank_b_pull_en(b_pull), .analog_sel(analog_sel),
        .irq_a(irq_a), .irq_b(irq_b));
    bioc_pin_model pa (.sys_clk(sys_clk), .pin_out(a_out), .pin_oe_n(a_oe_n),
        .pull_en(a_pull), .ext_en(ext_en_a), .ext_val(ext_val_a), .pin_in(a_in));
    bioc_pin_model pb (.sys_clk(sys_clk), .pin_out(b_out), .pin_oe_n(b_oe_n),
        .pull_en(b_pull), .ext_en(ext_en_b), .ext_val(ext_val_b), .pin_in(b_in));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        logic mapped;
        mapped = a inside {8'hC0, 8'hC1, 8'hC4, 8'hC5, 8'hCC, 8'hCD};
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk(16'({reg_hit, reg_rdata & line_mask}), 16'({mapped, exp}));
    endtask
    // edge modes: request three edges after the pin moves, then one cycle only
    task automatic edge_irq(input logic [1:0] m, input logic [7:0] v);
        @(posedge sys_clk);
        trig_mode_b <= m;
        ext_val_b <= v;
        n = 0;
        do begin
            @(posedge sys_clk);
            #1;
            n++;
        end while (irq_b !== 1'b1 && n < 8);
        chk(16'(n), 16'h0003);
        @(posedge sys_clk);
        #1;
        chk(16'(irq_b), 16'h0000);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (2000) @(posedge sys_clk);
        mismatches++;
        results();
    end
    initial begin
        repeat (8) @(posedge sys_clk);
        rstn <= 1'b1;
        foreach (rows[i]) begin
            wr(rows[i][23:16], rows[i][15:8]);
            rd(rows[i][23:16], rows[i][7:0]);
        end
        $display("register rows done");
        chk({a_out, a_oe_n}, 16'h5A42);
        chk({b_pull, b_oe_n}, 16'hF5FF);
        chk(analog_sel, 16'h0800);
        $display("pin modes done");
        edge_irq(BIOC_TRIG_FALL, 8'h0A);
        rd(8'hC1, 8'hFB);
        @(posedge sys_clk);
        trig_mode_b <= BIOC_TRIG_LOW;
        repeat (4) @(posedge sys_clk);
        #1;
        chk(16'(irq_b), 16'h0001);
        edge_irq(BIOC_TRIG_RISE, 8'h0E);
        $display("interrupts done");
        @(posedge sys_clk);
        rstn <= 1'b0;
        repeat (8) @(posedge sys_clk);
        chk({a_pull, b_oe_n}, 16'hFFFF);
        chk(analog_sel | {a_out, b_out}, 16'h0000);
        chk(16'({irq_a, irq_b, reg_hit, reg_rdata}), 16'h0000);
        rstn <= 1'b1;
        rd(8'hC4, 8'h00);
        rd(8'hCD, 8'h00);
        $display("reset done");
        // bank a line 0: pull-up input to interrupt input, pin held high outside
        wr(8'hCC, 8'h01);
        @(posedge sys_clk);
        ext_val_a <= 8'h00;
        repeat (2) @(posedge sys_clk);
        #1;
        chk(16'(irq_a), 16'h0000);
        @(posedge sys_clk);
        #1;
        chk(16'(irq_a), 16'h0001);
        @(posedge sys_clk);
        #1;
        chk(16'(irq_a), 16'h0000);
        @(posedge sys_clk);
        trig_mode_a <= BIOC_TRIG_LOW;
        repeat (2) @(posedge sys_clk);
        #1;
        chk(16'(irq_a), 16'h0001);
        $display("bank a interrupt done");
        results();
    end
endmodule
bind bioc_top bioc_top_assertions #(.W(W)) chk_i (.sys_clk(sys_clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
    .trig_mode_b(trig_mode_b), .bank_a_pin_oe_n(bank_a_pin_oe_n),
    .bank_a_pull_en(bank_a_pull_en), .bank_b_pin_oe_n(bank_b_pin_oe_n),
    .bank_b_pull_en(bank_b_pull_en), .analog_sel(analog_sel), .irq_b(irq_b));
